//--- rtl/pods_pkg.sv
// Notes on behaviour
// - Two 8-bit software-writable enable registers, high and low, gate pulse output per bit.
// - A pulse output reaches its pin only when its enable bit and its port direction bit are 1.
// - On the selected trigger, each enabled bit copies its staged data bit into its output level bit.
// - A bit whose enable is clear takes no copy on a trigger and keeps its level.
// - Two 8-bit output level registers, high and low, hold the pulse levels and reset to 0.
// - An output level bit whose enable is set ignores CPU writes; only triggers change it.
// - While a bit's enable is clear, CPU writes to its output level bit take effect to preset it.
// - Trigger copies happen only while the unit runs, never while module stop halts it.
// - Each 4-bit group selects its trigger from timer channel 0 to 3 by a 2-bit field reset to 11.
// - High-byte bits 15..12 form group 3 and bits 11..8 group 2, each triggered on its own.
package pods_pkg;
  localparam logic [2:0] ADDR_ENABLE_HIGH  = 3'h0;
  localparam logic [2:0] ADDR_ENABLE_LOW   = 3'h1;
  localparam logic [2:0] ADDR_LEVEL_HIGH   = 3'h2;
  localparam logic [2:0] ADDR_LEVEL_LOW    = 3'h3;
  localparam logic [2:0] ADDR_STAGED_HIGH  = 3'h4;
  localparam logic [2:0] ADDR_STAGED_LOW   = 3'h5;
  localparam logic [2:0] ADDR_TRIG_SELECT  = 3'h6;
  localparam logic [2:0] ADDR_CONTROL      = 3'h7;
  localparam logic [7:0] RESET_BYTE        = 8'h00;
  localparam logic [7:0] RESET_TRIG_SELECT = 8'hFF;
  localparam int         CONTROL_STOP_BIT  = 0;
  localparam int         GROUP_COUNT       = 4;
endpackage

//--- rtl/pods_stage.sv
`timescale 1ns/100ps
`default_nettype none
module pods_stage (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [2:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [7:0]  rdata,
  input  wire logic [3:0]  compare_match,
  input  wire logic [15:0] port_direction,
  output logic      [15:0] pulse_out,
  output logic      [15:0] pulse_out_en
);
  import pods_pkg::*;

  logic [7:0]  pulse_enable_high;
  logic [7:0]  pulse_enable_low;
  logic [7:0]  output_level_high;
  logic [7:0]  output_level_low;
  logic [7:0]  staged_data_high;
  logic [7:0]  staged_data_low;
  logic [7:0]  trigger_select_register;
  logic        module_stop;
  logic [15:0] enables;
  logic [15:0] levels;
  logic [15:0] staged;
  logic [15:0] write_mask;
  logic [15:0] write_data;
  logic [15:0] next_levels;
  logic [GROUP_COUNT-1:0] group_fire;

  assign enables = {pulse_enable_high, pulse_enable_low};
  assign levels  = {output_level_high, output_level_low};
  assign staged  = {staged_data_high, staged_data_low};
  assign write_data = {wdata, wdata};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pulse_enable_high <= RESET_BYTE;
      pulse_enable_low  <= RESET_BYTE;
    end else if (wr) begin
      if (addr == ADDR_ENABLE_HIGH) begin
        pulse_enable_high <= wdata;
      end
      if (addr == ADDR_ENABLE_LOW) begin
        pulse_enable_low <= wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      staged_data_high <= RESET_BYTE;
      staged_data_low  <= RESET_BYTE;
      module_stop      <= 1'b0;
    end else if (wr) begin
      if (addr == ADDR_STAGED_HIGH) begin
        staged_data_high <= wdata;
      end
      if (addr == ADDR_STAGED_LOW) begin
        staged_data_low <= wdata;
      end
      if (addr == ADDR_CONTROL) begin
        module_stop <= wdata[CONTROL_STOP_BIT];
      end
    end
  end

  // Trigger select, resets to channel 3
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      trigger_select_register <= RESET_TRIG_SELECT;
    end else if (wr && addr == ADDR_TRIG_SELECT) begin
      trigger_select_register <= wdata;
    end
  end

  // Byte lanes of a CPU write to the level registers
  always_comb begin
    write_mask = 16'h0000;
    if (wr && addr == ADDR_LEVEL_HIGH) begin
      write_mask = 16'hFF00;
    end
    if (wr && addr == ADDR_LEVEL_LOW) begin
      write_mask = 16'h00FF;
    end
  end

  genvar g;
  generate
    for (g = 0; g < GROUP_COUNT; g++) begin : gen_group
      assign group_fire[g] = !module_stop &&
                             compare_match[trigger_select_register[2*g +: 2]];
    end
  endgenerate

  // Trigger wins on enabled bits; software only on disabled ones
  genvar b;
  generate
    for (b = 0; b < 16; b++) begin : gen_bit
      // Copy on trigger, enabled bits only
      assign next_levels[b] = enables[b] ?
                              (group_fire[b/4] ? staged[b] : levels[b]) :
                              (write_mask[b] ? write_data[b] : levels[b]);
    end
  endgenerate

  // Level registers reset to zero
  // One process for both bytes, so no bit has two drivers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      output_level_high <= RESET_BYTE;
      output_level_low  <= RESET_BYTE;
    end else begin
      output_level_high <= next_levels[15:8];
      output_level_low  <= next_levels[7:0];
    end
  end

  // Pins straight from level bits, gated by enable and direction
  assign pulse_out    = levels & enables & port_direction;
  assign pulse_out_en = enables & port_direction;

  // Read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        ADDR_ENABLE_HIGH: rdata <= pulse_enable_high;
        ADDR_ENABLE_LOW:  rdata <= pulse_enable_low;
        ADDR_LEVEL_HIGH:  rdata <= output_level_high;
        ADDR_LEVEL_LOW:   rdata <= output_level_low;
        ADDR_STAGED_HIGH: rdata <= staged_data_high;
        ADDR_STAGED_LOW:  rdata <= staged_data_low;
        ADDR_TRIG_SELECT: rdata <= trigger_select_register;
        ADDR_CONTROL:     rdata <= {7'h00, module_stop};
        default:          rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule
`default_nettype wire

//--- verif/pods_timer.sv
`timescale 1ns/100ps
`default_nettype none
// Timer side: one-cycle match pulse per request
module pods_timer (
  input  wire logic       clk,
  input  wire logic [3:0] fire,
  output logic      [3:0] compare_match
);
  always_ff @(posedge clk) begin
    compare_match <= fire;
  end
endmodule
`default_nettype wire

//--- verif/pods_stage_chk.sv
`timescale 1ns/100ps
`default_nettype none
module pods_stage_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [2:0]  addr,
  input wire logic [7:0]  wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [7:0]  rdata,
  input wire logic [3:0]  compare_match,
  input wire logic [15:0] port_direction,
  input wire logic [15:0] pulse_out,
  input wire logic [15:0] pulse_out_en
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_en_in_dir: assert property ((pulse_out_en & ~port_direction) == 16'h0000)
    else $error("pin driven without direction");
  a_out_in_en: assert property ((pulse_out & ~pulse_out_en) == 16'h0000)
    else $error("pulse on undriven pin");
  a_en_high: assert property (wr && addr == 3'h0 |=>
    pulse_out_en[15:8] == ($past(wdata) & port_direction[15:8])) else $error("high enable");
  a_en_low: assert property (wr && addr == 3'h1 |=>
    pulse_out_en[7:0] == ($past(wdata) & port_direction[7:0])) else $error("low enable");
  a_rd_idle: assert property (!rd |=> rdata == 8'h00) else $error("stray read data");
  a_read_en: assert property (rd && addr == 3'h0 |=>
    (rdata & $past(port_direction[15:8])) == $past(pulse_out_en[15:8])) else $error("read");
  a_quiet_hold: assert property (!wr && compare_match == 4'h0 ##1
    $stable(port_direction) |-> $stable(pulse_out)) else $error("level moved");
  a_level_lock: assert property (wr && addr == 3'h2 && compare_match == 4'h0 &&
    pulse_out_en[15:8] == 8'hFF ##1 $stable(port_direction) |-> $stable(pulse_out[15:8]))
    else $error("locked level written");
  c_trig: cover property (compare_match != 4'h0 ##1 pulse_out != 16'h0000);
  c_wr: cover property (wr && addr == 3'h2);
  c_rd: cover property (rd ##1 rdata != 8'h00);
endmodule
bind pods_stage pods_stage_chk u_chk (.*);
`default_nettype wire

//--- verif/pods_stage_test.sv
`timescale 1ns/100ps
`default_nettype none
module pods_stage_test;
  logic clk, rst_n, wr, rd;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, lvl;
  logic [3:0] fire, cm;
  logic [15:0] dir, po, poe;
  logic [31:0] seed;
  int i, cyc, num_errors, total_checks;
  pods_timer tmr (.clk(clk), .fire(fire), .compare_match(cm));
  pods_stage dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .compare_match(cm), .port_direction(dir), .pulse_out(po), .pulse_out_en(poe));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13; s ^= s >> 17; s ^= s << 5;
    return s;
  endfunction
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %0t got %h want %h", $time, s, e);
    end
  endtask
  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk); addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
  endtask
  task automatic rchk(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk); addr <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  // Timer model adds one cycle before the match
  task automatic trig(input logic [3:0] m);
    @(posedge clk); fire <= m;
    @(posedge clk); fire <= 4'h0;
    @(posedge clk); #1;
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      num_errors++;
      wrap_up;
    end
  end
  initial begin
    rst_n = 0; wr = 0; rd = 0; addr = 3'h0; wdata = 8'h00; fire = 4'h0;
    dir = 16'hFFFF; seed = 32'h00012808; lvl = 8'h00;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 4; i++) rchk(i[2:0], 8'h00);
    rchk(3'h6, 8'hFF);
    wreg(3'h2, 8'h5A); rchk(3'h2, 8'h5A);
    wreg(3'h4, 8'hA5); wreg(3'h0, 8'hF0); trig(4'h8); chk(po[15:8], 8'hA0);
    rchk(3'h2, 8'hAA);
    wreg(3'h0, 8'hFF); wreg(3'h2, 8'h00); rchk(3'h2, 8'hAA);
    wreg(3'h1, 8'hFF);
    for (i = 0; i < 4; i++) begin
      seed = xs(seed);
      @(posedge clk); dir <= seed[31:16];
      wreg(3'h6, {4{i[1:0]}}); wreg(3'h5, seed[7:0]);
      trig(~(4'h1 << i)); chk(po[7:0], lvl & dir[7:0]);
      trig(4'h1 << i); lvl = seed[7:0]; chk(po[7:0], lvl & dir[7:0]);
    end
    wreg(3'h7, 8'h01); wreg(3'h5, 8'h3C); trig(4'hF); chk(po[7:0], lvl & dir[7:0]);
    wreg(3'h7, 8'h00); trig(4'hF); chk(po[7:0], 8'h3C & dir[7:0]);
    wrap_up;
  end
endmodule
`default_nettype wire
